// ### core/dbla_apb.sv
// Purpose: APB slave handshake with one wait state
// Assumes: Read word and map hit are decoded by the parent
// Notes: Unmapped accesses complete with pslverr

`timescale 1ns/10ps
`default_nettype none

module dbla_apb
   import dbla_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic mapped,
   input wire logic [DATA_W-1:0] rd_word,
   output var logic pready,
   output var logic [DATA_W-1:0] prdata,
   output var logic pslverr,
   output logic wr_fire
);

   logic pready_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic pslverr_reg;
   wire access = psel & penable;
   wire first = access & ~pready_reg;

   assign wr_fire = access & pready_reg & pwrite & mapped;
   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // Answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= first;
         prdata_reg <= (first & ~pwrite & mapped) ? rd_word : 32'h00000000;
         pslverr_reg <= first & ~mapped;
      end
   end

endmodule

`default_nettype wire

// ### core/dbla_core.sv
// Purpose: Display-buffer access through an interface latch, independent mode
// Assumes: hblank and vblank come from raster timing, synchronous to pclk
// Notes: Commands are taken only while the done flag is set
//
// The implementer's own choices: the register offsets and the APB interface to the registers.

`timescale 1ns/10ps
`default_nettype none

// How it works
// - Data moves only through latch, own strobes
// - Address from cursor or pointer, command chooses
// - Transfers happen only inside blanking intervals
// - Read and write at pointer address
// - Cursor read/write, with or without increment
// - Write clears flag, stores latch at address
// - Done flag set after write stores
// - Read clears flag, loads latch, sets flag
// - Fill writes cursor through pointer from latch
// - Conditions visible in pollable status register
// - Four configurations; only independent runs commands
// - Fill steps addresses, flag set at end
// - Active window waits hblank; blanked runs now
// - Fill forces blank until next vertical retrace
// - Ready output signals command completion
module dbla_core
   import dbla_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output var logic pready,
   output var logic [DATA_W-1:0] prdata,
   output var logic pslverr,
   input wire logic hblank,
   input wire logic vblank,
   output var logic [ADDR_W-1:0] buf_addr,
   output var logic latch_read_strobe,
   output var logic latch_write_strobe,
   output var logic buffer_chip_select,
   output var logic buf_write_en,
   output var logic blank_out,
   output var logic ready_irq
);

   dbla_state_t state_reg, state_next;
   logic [ADDR_W-1:0] cursor_reg, pointer_reg, addr_reg;
   logic [2:0] cmd_reg;
   logic [2:0] config_reg;
   logic done_reg, ready_reg, reject_reg, blank_reg, go_reg;
   logic wr_fire, cyc_last;

   // Register decode
   wire hit_cmd = dbla_hit(paddr, OFS_COMMAND);
   wire hit_cur = dbla_hit(paddr, OFS_CURSOR);
   wire hit_ptr = dbla_hit(paddr, OFS_POINTER);
   wire hit_st = dbla_hit(paddr, OFS_STATUS);
   wire hit_cfg = dbla_hit(paddr, OFS_CONFIG);
   wire mapped = hit_cmd | hit_cur | hit_ptr | hit_st | hit_cfg;
   wire [1:0] mode = config_reg[CFG_MODE_LSB +: 2];
   wire cfg_blank = config_reg[CFG_BLANK_BIT];
   wire [2:0] new_cmd = pwdata[CMD_W-1:0];
   wire cmd_write = wr_fire & hit_cmd & (new_cmd != CMD_NONE);
   wire cmd_ok = done_reg & (mode == MODE_INDEPENDENT);
   wire cmd_take = cmd_write & cmd_ok;
   wire cmd_reject = cmd_write & ~cmd_ok;

   // Command attributes
   wire is_fill = (cmd_reg == CMD_FILL);
   wire is_write = (cmd_reg == CMD_WR_PTR) | (cmd_reg == CMD_WR_CUR) | (cmd_reg == CMD_WR_CUR_INC) | is_fill;
   wire use_ptr = (cmd_reg == CMD_RD_PTR) | (cmd_reg == CMD_WR_PTR);
   wire is_inc = (cmd_reg == CMD_RD_CUR_INC) | (cmd_reg == CMD_WR_CUR_INC);
   wire [ADDR_W-1:0] sel_addr = use_ptr ? pointer_reg : cursor_reg;
   wire can_go = hblank | vblank | cfg_blank;
   wire fill_more = is_fill & (addr_reg != pointer_reg);
   wire finish = (state_reg == DBLA_XFER) & cyc_last & ~fill_more;

   wire [DATA_W-1:0] status_word = {27'h0000000, (state_reg != DBLA_IDLE), blank_reg,
      reject_reg, ready_reg, done_reg};
   wire [DATA_W-1:0] rd_word = hit_cur ? {21'h000000, cursor_reg} :
      hit_ptr ? {21'h000000, pointer_reg} :
      hit_st ? status_word :
      hit_cfg ? {29'h00000000, config_reg} :
      {29'h00000000, cmd_reg};

   dbla_apb i_dbla_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .mapped(mapped),
      .rd_word(rd_word),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .wr_fire(wr_fire)
   );

   // Sequencer
   logic go_next;
   logic [ADDR_W-1:0] addr_next;
   always_comb
   begin
      state_next = state_reg;
      go_next = 1'b0;
      addr_next = addr_reg;
      unique case (state_reg)
         DBLA_IDLE:
         begin
            if (cmd_take && new_cmd == CMD_FILL)
            begin
               state_next = DBLA_XFER;
               go_next = 1'b1;
               addr_next = cursor_reg;
            end
            else if (cmd_take)
               state_next = DBLA_WAIT;
         end
         DBLA_WAIT:
         begin
            if (can_go)
            begin
               state_next = DBLA_XFER;
               go_next = 1'b1;
               addr_next = sel_addr;
            end
         end
         DBLA_XFER:
         begin
            if (cyc_last && fill_more)
            begin
               go_next = 1'b1;
               addr_next = ADDR_W'(addr_reg + 11'h001);
            end
            else if (cyc_last)
               state_next = DBLA_IDLE;
         end
      endcase
   end

   dbla_cycle i_dbla_cycle (
      .pclk(pclk),
      .presetn(presetn),
      .go(go_reg),
      .is_write(is_write),
      .cs(buffer_chip_select),
      .rd_stb(latch_read_strobe),
      .wr_stb(latch_write_strobe),
      .we(buf_write_en),
      .last(cyc_last)
   );

   assign buf_addr = addr_reg;
   assign blank_out = blank_reg;
   assign ready_irq = ready_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= DBLA_IDLE;
         go_reg <= 1'b0;
         addr_reg <= RST_ADDR;
         cmd_reg <= CMD_NONE;
         done_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         go_reg <= go_next;
         addr_reg <= addr_next;
         if (cmd_take)
            cmd_reg <= new_cmd;
         if (cmd_take)
            done_reg <= 1'b0;
         else if (finish)
            done_reg <= 1'b1;
      end
   end

   // Software-visible registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cursor_reg <= RST_ADDR;
         pointer_reg <= RST_ADDR;
         config_reg <= RST_CONFIG;
      end
      else
      begin
         if (finish && is_inc)
            cursor_reg <= ADDR_W'(cursor_reg + 11'h001);
         else if (wr_fire && hit_cur)
            cursor_reg <= pwdata[ADDR_W-1:0];
         if (wr_fire && hit_ptr)
            pointer_reg <= pwdata[ADDR_W-1:0];
         if (wr_fire && hit_cfg)
            config_reg <= pwdata[2:0];
      end
   end

   // Flags; a hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready_reg <= 1'b0;
         reject_reg <= 1'b0;
         blank_reg <= 1'b0;
      end
      else
      begin
         if (finish)
            ready_reg <= 1'b1;
         else if (cmd_take)
            ready_reg <= 1'b0;
         if (cmd_reject)
            reject_reg <= 1'b1;
         else if (wr_fire && hit_st && pwdata[ST_REJECT_BIT])
            reject_reg <= 1'b0;
         if (cmd_take && new_cmd == CMD_FILL)
            blank_reg <= 1'b1;
         else if (state_reg == DBLA_IDLE && vblank)
            blank_reg <= 1'b0;
      end
   end

   logic fill_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fill_q <= 1'b0;
      else
         fill_q <= is_fill;
   end

   a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == DBLA_IDLE) |-> (!buffer_chip_select && !latch_write_strobe && !latch_read_strobe))
      else $error("strobe active while idle");
   a_idle_done: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == DBLA_IDLE) |-> done_reg)
      else $error("done flag low while idle");
   a_take_clears: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_take |=> (!done_reg && !ready_irq))
      else $error("done flag not cleared by command");
   a_go_blanked: assert property (@(posedge pclk) disable iff (!presetn)
      (go_next && state_reg == DBLA_WAIT) |-> can_go)
      else $error("access started outside blanking");
   a_wait_start: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == DBLA_WAIT && can_go) |=> (go_reg && state_reg == DBLA_XFER))
      else $error("blanked wait did not start");
   a_addr_select: assert property (@(posedge pclk) disable iff (!presetn)
      (go_reg && !is_fill && $past(state_reg) == DBLA_WAIT) |-> buf_addr == sel_addr)
      else $error("wrong buffer address");
   a_write_strobe: assert property (@(posedge pclk) disable iff (!presetn)
      buf_write_en |-> (latch_write_strobe && buffer_chip_select && is_write))
      else $error("write enable without latch drive");
   a_read_loads: assert property (@(posedge pclk) disable iff (!presetn)
      (finish && !is_write) |-> (latch_read_strobe ##1 (done_reg && ready_irq)))
      else $error("read did not load latch then set flag");
   a_cursor_inc: assert property (@(posedge pclk) disable iff (!presetn)
      (finish && is_inc) |=> cursor_reg == ADDR_W'($past(cursor_reg) + 11'h001))
      else $error("cursor not advanced by one");
   a_fill_blank: assert property (@(posedge pclk) disable iff (!presetn)
      (fill_q && state_reg == DBLA_XFER) |-> blank_out)
      else $error("blank not forced during fill");
   a_fill_rate: assert property (@(posedge pclk) disable iff (!presetn)
      (go_reg && is_fill) |=> (buffer_chip_select [*2]) ##1 !buffer_chip_select)
      else $error("fill location not two character times");

   c_write: cover property (@(posedge pclk) disable iff (!presetn)
      finish && is_write && !is_fill);
   c_read: cover property (@(posedge pclk) disable iff (!presetn)
      finish && !is_write);
   c_fill: cover property (@(posedge pclk) disable iff (!presetn)
      finish && is_fill && addr_reg != cursor_reg);
   c_reject: cover property (@(posedge pclk) disable iff (!presetn)
      cmd_reject);

endmodule

`default_nettype wire

// ### core/dbla_cycle.sv
// Purpose: One buffer location access of two character times
// Assumes: go arrives only while idle
// Notes: last marks the final cycle of the access

`timescale 1ns/10ps
`default_nettype none

module dbla_cycle
   import dbla_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic is_write,
   output var logic cs,
   output var logic rd_stb,
   output var logic wr_stb,
   output var logic we,
   output logic last
);

   logic busy_reg;
   logic wr_reg;
   logic [1:0] cnt_reg;
   logic cs_reg;
   logic rd_reg;
   logic ws_reg;
   logic we_reg;
   wire busy_next = go | (busy_reg & (cnt_reg != LOC_LAST));
   wire [1:0] cnt_next = go ? 2'h0 : 2'(cnt_reg + 2'h1);
   wire wr_next = go ? is_write : wr_reg;
   wire end_next = busy_next & (cnt_next == LOC_LAST);

   assign last = busy_reg & (cnt_reg == LOC_LAST);
   assign cs = cs_reg;
   assign rd_stb = rd_reg;
   assign wr_stb = ws_reg;
   assign we = we_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_reg <= 1'b0;
         wr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         cs_reg <= 1'b0;
         rd_reg <= 1'b0;
         ws_reg <= 1'b0;
         we_reg <= 1'b0;
      end
      else
      begin
         busy_reg <= busy_next;
         wr_reg <= wr_next;
         cnt_reg <= cnt_next;
         cs_reg <= busy_next;
         ws_reg <= busy_next & wr_next;
         we_reg <= end_next & wr_next;
         rd_reg <= end_next & ~wr_next;
      end
   end

endmodule

`default_nettype wire

// ### core/dbla_pkg.sv
// Purpose: Shared constants for the display-buffer latch access sequencer
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes: Command codes and register offsets are fixed here only

package dbla_pkg;

   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_CURSOR = 8'h04;
   localparam logic [7:0] OFS_POINTER = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_CONFIG = 8'h10;

   // Command codes in the low bits of a command write
   localparam int unsigned CMD_W = 3;
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_RD_PTR = 3'h1;
   localparam logic [2:0] CMD_WR_PTR = 3'h2;
   localparam logic [2:0] CMD_RD_CUR = 3'h3;
   localparam logic [2:0] CMD_WR_CUR = 3'h4;
   localparam logic [2:0] CMD_RD_CUR_INC = 3'h5;
   localparam logic [2:0] CMD_WR_CUR_INC = 3'h6;
   localparam logic [2:0] CMD_FILL = 3'h7;

   // Buffer interface configurations
   localparam logic [1:0] MODE_INDEPENDENT = 2'h0;
   localparam logic [1:0] MODE_TRANSPARENT = 2'h1;
   localparam logic [1:0] MODE_SHARED = 2'h2;
   localparam logic [1:0] MODE_ROW = 2'h3;

   // Field positions
   localparam int unsigned ST_DONE_BIT = 0;
   localparam int unsigned ST_READY_BIT = 1;
   localparam int unsigned ST_REJECT_BIT = 2;
   localparam int unsigned ST_BLANK_BIT = 3;
   localparam int unsigned ST_BUSY_BIT = 4;
   localparam int unsigned CFG_MODE_LSB = 0;
   localparam int unsigned CFG_BLANK_BIT = 2;

   // Reset values
   localparam logic [ADDR_W-1:0] RST_ADDR = 11'h000;
   localparam logic [2:0] RST_CONFIG = 3'h0;

   // One location per two character times; character time is one pclk here
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned CHAR_TIME_NS = 100;
   localparam int unsigned LOC_CHAR_TIMES = 2;
   localparam int unsigned LOC_CYCLES = (LOC_CHAR_TIMES * CHAR_TIME_NS) / CLK_PERIOD_NS;
   localparam logic [1:0] LOC_LAST = 2'(LOC_CYCLES - 1);

   typedef enum logic [2:0] {
      DBLA_IDLE = 3'b001,
      DBLA_WAIT = 3'b010,
      DBLA_XFER = 3'b100
   } dbla_state_t;

   function automatic logic dbla_hit(input logic [7:0] addr, input logic [7:0] ofs);
      dbla_hit = (addr == ofs);
   endfunction

endpackage

// ### dv/dbla_core_test.sv
// Purpose: Self-checking bench for the latch access sequencer
// Assumes: APB master tasks, RAM model on the far side
// Notes: Host commands run in sequence with done polling

`timescale 1ns/10ps
`default_nettype none

module dbla_core_test
   import dbla_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PADDR_W-1:0] paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = 32'h0;
   logic pready, pslverr, latch_read_strobe, latch_write_strobe;
   logic buffer_chip_select, buf_write_en, blank_out, ready_irq, last_err;
   logic [DATA_W-1:0] prdata, r;
   logic hblank = 1'b0;
   logic vblank = 1'b0;
   logic host_load = 1'b0;
   logic [7:0] host_data = 8'h00;
   logic [7:0] latch_q;
   logic [ADDR_W-1:0] buf_addr;
   int failures = 0;
   int samples_checked = 0;
   int cs_count = 0;
   int c0;

   always #50 pclk = ~pclk;

   always @(posedge pclk)
      if (buffer_chip_select === 1'b1)
         cs_count++;

   dbla_core i_dbla_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .hblank(hblank),
      .vblank(vblank), .buf_addr(buf_addr), .latch_read_strobe(latch_read_strobe),
      .latch_write_strobe(latch_write_strobe), .buffer_chip_select(buffer_chip_select),
      .buf_write_en(buf_write_en), .blank_out(blank_out), .ready_irq(ready_irq));

   dbla_ram_model i_dbla_ram_model (.pclk(pclk), .buf_addr(buf_addr), .latch_read_strobe(latch_read_strobe),
      .latch_write_strobe(latch_write_strobe), .buffer_chip_select(buffer_chip_select),
      .buf_write_en(buf_write_en), .host_load(host_load), .host_data(host_data), .latch_q(latch_q));

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         failures++;
         $display("wrong value at %0t: no bus answer", $time);
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask

   task automatic put(input logic [7:0] d);
      @(posedge pclk);
      host_load <= 1'b1;
      host_data <= d;
      @(posedge pclk);
      host_load <= 1'b0;
   endtask

   task automatic wait_done();
      logic [31:0] s = 32'h0;
      int n = 0;
      while (s[ST_DONE_BIT] !== 1'b1 && n < 100)
      begin
         apb(1'b0, OFS_STATUS, 32'h0, s);
         n++;
      end
      if (s[ST_DONE_BIT] !== 1'b1)
      begin
         failures++;
         $display("wrong value at %0t: done flag never set", $time);
      end
   endtask

   task automatic do_cmd(input logic [2:0] c);
      wait_done();
      wr(OFS_COMMAND, {29'h0, c});
      wait_done();
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      conclude();
   end

   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_STATUS, 32'h0, r);
      check_word(r, 32'h1);
      check_bit(buffer_chip_select | latch_read_strobe | latch_write_strobe, 1'b0);
      vblank <= 1'b1;
      put(8'hA5);
      wr(OFS_POINTER, 32'h5);
      do_cmd(CMD_WR_PTR);
      check_word(i_dbla_ram_model.mem[5], 32'hA5);
      check_bit(ready_irq, 1'b1);
      put(8'h00);
      do_cmd(CMD_RD_PTR);
      check_word(latch_q, 32'hA5);
      wr(OFS_CURSOR, 32'h7FF);
      put(8'h3C);
      do_cmd(CMD_WR_CUR_INC);
      check_word(i_dbla_ram_model.mem[2047], 32'h3C);
      apb(1'b0, OFS_CURSOR, 32'h0, r);
      check_word(r, 32'h0);
      put(8'h5A);
      do_cmd(CMD_WR_CUR);
      check_word(i_dbla_ram_model.mem[0], 32'h5A);
      apb(1'b0, OFS_CURSOR, 32'h0, r);
      check_word(r, 32'h0);
      put(8'h00);
      do_cmd(CMD_RD_CUR_INC);
      check_word(latch_q, 32'h5A);
      apb(1'b0, OFS_CURSOR, 32'h0, r);
      check_word(r, 32'h1);
      wr(OFS_CURSOR, 32'h7FF);
      do_cmd(CMD_RD_CUR);
      check_word(latch_q, 32'h3C);
      apb(1'b0, OFS_CURSOR, 32'h0, r);
      check_word(r, 32'h7FF);
      vblank <= 1'b0;
      put(8'h77);
      wr(OFS_POINTER, 32'h20);
      c0 = cs_count;
      wr(OFS_COMMAND, {29'h0, CMD_WR_PTR});
      repeat (20) @(posedge pclk);
      check_word(cs_count - c0, 32'h0);
      check_word(i_dbla_ram_model.mem[32], 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0, r);
      check_word(r, 32'h1 << ST_BUSY_BIT);
      hblank <= 1'b1;
      wait_done();
      check_word(i_dbla_ram_model.mem[32], 32'h77);
      hblank <= 1'b0;
      wr(OFS_CONFIG, 32'h4);
      put(8'h11);
      wr(OFS_POINTER, 32'h21);
      do_cmd(CMD_WR_PTR);
      check_word(i_dbla_ram_model.mem[33], 32'h11);
      wr(OFS_CONFIG, 32'h0);
      put(8'h20);
      wr(OFS_CURSOR, 32'h10);
      wr(OFS_POINTER, 32'h13);
      c0 = cs_count;
      wr(OFS_COMMAND, {29'h0, CMD_FILL});
      @(posedge pclk);
      check_bit(blank_out, 1'b1);
      wait_done();
      check_word(cs_count - c0, 32'h8);
      for (int i = 16; i < 20; i++)
         check_word(i_dbla_ram_model.mem[i], 32'h20);
      check_word(i_dbla_ram_model.mem[20], 32'h0);
      check_bit(blank_out, 1'b1);
      vblank <= 1'b1;
      repeat (3) @(posedge pclk);
      check_bit(blank_out, 1'b0);
      wr(OFS_CONFIG, 32'h1);
      wr(OFS_COMMAND, {29'h0, CMD_WR_PTR});
      apb(1'b0, OFS_STATUS, 32'h0, r);
      check_word(r & 32'h5, 32'h5);
      wr(OFS_STATUS, 32'h4);
      apb(1'b0, OFS_STATUS, 32'h0, r);
      check_word(r & 32'h4, 32'h0);
      wr(OFS_CONFIG, 32'h0);
      apb(1'b0, 8'h20, 32'h0, r);
      check_bit(last_err, 1'b1);
      check_word(r, 32'h0);
      conclude();
   end
endmodule

`default_nettype wire

// ### dv/dbla_ram_model.sv
// Purpose: Display RAM behind the interface latch, far side of the block
// Assumes: Host loads the latch through host_load
// Notes: RAM is 2K bytes, cleared at time zero

`timescale 1ns/10ps
`default_nettype none

module dbla_ram_model
   import dbla_pkg::*;
(
   input wire logic pclk,
   input wire logic [ADDR_W-1:0] buf_addr,
   input wire logic latch_read_strobe,
   input wire logic latch_write_strobe,
   input wire logic buffer_chip_select,
   input wire logic buf_write_en,
   input wire logic host_load,
   input wire logic [7:0] host_data,
   output var logic [7:0] latch_q
);
   logic [7:0] mem [0:2047];
   logic [7:0] latch_reg;

   initial
   begin
      for (int i = 0; i < 2048; i++)
         mem[i] = 8'h00;
   end

   assign latch_q = latch_reg;

   always @(posedge pclk)
   begin
      if (host_load)
         latch_reg <= host_data;
      else if (buffer_chip_select && latch_read_strobe)
         latch_reg <= mem[buf_addr];
      if (buffer_chip_select && latch_write_strobe && buf_write_en)
         mem[buf_addr] <= latch_reg;
   end
endmodule

`default_nettype wire
